/* File: bench/dpw_wake_src.sv */
// Purpose: Wake-capable devices, modem ring and power event source
// Assumes: One clock, pulses commanded by the bench
// Notes:   All lines idle low outside a pulse
`timescale 1ns/1ps
`default_nettype none
module dpw_wake_src #(
    parameter int unsigned NDEV = 4
) (
    input  wire logic       clk,
    output var logic        pwr_status_event,
    output var logic [NDEV-1:0] dev_wake,
    output var logic        ring_detect_line
);
    // Idle: no event, no wake, no ring
    initial begin
        pwr_status_event = 1'b0;
        dev_wake         = '0;
        ring_detect_line = 1'b0;
    end
    // One-cycle pulse on source n: 0 power, 1 ring, 2 and up bridged device
    task automatic pulse(input int n);
        @(posedge clk);
        if (n == 0) pwr_status_event <= 1'b1;
        else if (n == 1) ring_detect_line <= 1'b1;
        else dev_wake[n-2] <= 1'b1;
        @(posedge clk);
        pwr_status_event <= 1'b0;
        ring_detect_line <= 1'b0;
        dev_wake         <= '0;
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the power and wake core
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Expected values come from the register map and state codes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, rst_n, wr, rd;       // Clock, reset, strobes
    logic [7:0]  addr;                     // Register address
    logic [31:0] wdata, rdata;             // Register data
    logic        pwr_ev, ring, sci, sys_sleep, sys_resume;
    logic        main_en, aux_en, main_iso, aux_iso, lp_req, off_req;
    logic        ctrl_on, ctx_keep, phone_on, spk_en, on_hook;
    logic [3:0]  dev;                      // Bridged wake lines
    int          fails, total_checks;      // Tallies
    dpw_core i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .pwr_status_event(pwr_ev), .dev_wake(dev),
        .ring_detect_line(ring), .sci(sci), .sys_sleep(sys_sleep), .sys_resume(sys_resume),
        .main_plane_en(main_en), .aux_plane_enable_line(aux_en), .main_iso(main_iso),
        .aux_iso(aux_iso), .modem_low_power_request(lp_req), .modem_off_request(off_req),
        .modem_ctrl_on(ctrl_on), .modem_ctx_keep(ctx_keep), .phone_if_on(phone_on),
        .speaker_en(spk_en), .force_on_hook(on_hook));
    dpw_wake_src i_src (.clk(clk), .pwr_status_event(pwr_ev), .dev_wake(dev),
        .ring_detect_line(ring));
    // Clock: 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Compare and tally
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One-cycle register write
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // One-cycle read, data checked in the following cycle
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(name, rdata, exp);
    endtask
    // Modem decode outputs packed for one compare
    task automatic modem(input logic [6:0] exp);
        check("modem", {25'h0, ctrl_on, ctx_keep, phone_on, spk_en, on_hook, lp_req, off_req}, {25'h0, exp});
    endtask
    // Let planes settle, then sample
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Verdict
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("pst", dpw_pkg::OFS_PST, 32'h0000006C);
        modem(7'h78);
        check("planes", {28'h0, main_en, aux_en, main_iso, aux_iso}, 32'hC);
        rd_chk("unmapped", 8'h20, 32'h0);
        wr_reg(dpw_pkg::OFS_EN, 32'h1);
        i_src.pulse(0);
        #1 check("sci", {31'h0, sci}, 32'h1);
        rd_chk("sts", dpw_pkg::OFS_STS, 32'h1);
        wr_reg(dpw_pkg::OFS_STS, 32'h1);
        @(posedge clk);
        #1 check("sci", {31'h0, sci}, 32'h0);
        wr_reg(dpw_pkg::OFS_CTL, 32'h13);
        i_src.pulse(1);
        repeat (2) @(posedge clk);
        #1 check("sleep", {31'h0, sys_sleep}, 32'h1);
        rd_chk("sts", dpw_pkg::OFS_STS, 32'h0);
        wr_reg(dpw_pkg::OFS_WEN, 32'h2);
        wr_reg(dpw_pkg::OFS_EN, 32'h2);
        i_src.pulse(1);
        #1 check("wake", {29'h0, sys_resume, sys_sleep, sci}, 32'h5);
        @(posedge clk);
        #1 check("resume", {31'h0, sys_resume}, 32'h0);
        rd_chk("src", dpw_pkg::OFS_SRC, 32'h80000002);
        wr_reg(dpw_pkg::OFS_STS, 32'h2);
        rd_chk("sts", dpw_pkg::OFS_STS, 32'h0);
        rd_chk("src", dpw_pkg::OFS_SRC, 32'h80000002);
        wr_reg(dpw_pkg::OFS_CTL, 32'h1);
        settle();
        check("aux", {30'h0, aux_en, aux_iso}, 32'h1);
        wr_reg(dpw_pkg::OFS_CTL, 32'h5);
        settle();
        modem(7'h66);
        rd_chk("pst", dpw_pkg::OFS_PST, 32'h25);
        wr_reg(dpw_pkg::OFS_CTL, 32'h3);
        settle();
        modem(7'h78);
        check("aux_on", {30'h0, aux_en, aux_iso}, 32'h2);
        wr_reg(dpw_pkg::OFS_CTL, 32'h9);
        settle();
        modem(7'h05);
        check("main_kept", {30'h0, main_en, main_iso}, 32'h2);
        wr_reg(dpw_pkg::OFS_CTL, 32'h8);
        settle();
        modem(7'h05);
        check("main", {30'h0, main_en, main_iso}, 32'h1);
        rd_chk("pst", dpw_pkg::OFS_PST, 32'h03);
        wr_reg(dpw_pkg::OFS_WEN, 32'h4);
        wr_reg(dpw_pkg::OFS_CTL, 32'h18);
        i_src.pulse(2);
        #1 check("resume", {31'h0, sys_resume}, 32'h1);
        rd_chk("src", dpw_pkg::OFS_SRC, 32'h80000004);
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: common/dpw_pkg.sv */
// Purpose: Shared constants for the device power and wake block
// Assumes: 32-bit register port, byte offsets on word boundaries
// Notes:   Device states use a two-bit code, D0 to D3
package dpw_pkg;

    // ****************************************
    // Register port
    // ****************************************
    localparam int unsigned DW = 32;               // Data width
    localparam int unsigned AW = 8;                // Address width

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_STS = 8'h00;        // Event status, write one to clear
    localparam logic [7:0] OFS_EN  = 8'h04;        // Event enable toward the SCI
    localparam logic [7:0] OFS_WEN = 8'h08;        // Per-source wake enable
    localparam logic [7:0] OFS_SRC = 8'h0C;        // Recorded wake source
    localparam logic [7:0] OFS_CTL = 8'h10;        // Plane and modem control
    localparam logic [7:0] OFS_PST = 8'h14;        // Power state readback

    // ****************************************
    // Event vector bit positions
    // ****************************************
    localparam int unsigned EV_PWR  = 0;           // Power status change
    localparam int unsigned EV_RING = 1;           // Modem ring wake
    localparam int unsigned EV_DEV  = 2;           // First bridged device wake

    // ****************************************
    // Control register fields and wake record valid bit
    // ****************************************
    localparam int unsigned CTL_W     = 4;         // Stored control bits
    localparam int unsigned CTL_MAIN  = 0;         // Main plane enable
    localparam int unsigned CTL_AUX   = 1;         // Aux plane enable
    localparam int unsigned CTL_LP    = 2;         // Modem low-power request
    localparam int unsigned CTL_OFF   = 3;         // Modem off request
    localparam int unsigned CTL_SLEEP = 4;         // Write one: system sleeps
    localparam logic [3:0]  CTL_RST   = 4'h3;      // Both planes on, modem in D0
    localparam int unsigned SRC_VLD   = 31;        // Wake record valid bit

    // ****************************************
    // Power state readback fields
    // ****************************************
    localparam int unsigned PST_DST   = 0;         // Two-bit device state
    localparam int unsigned PST_NMAIN = 2;         // Main plane needed
    localparam int unsigned PST_NAUX  = 3;         // Aux plane needed
    localparam int unsigned PST_SLP   = 4;         // System sleeping or resuming
    localparam int unsigned PST_MON   = 5;         // Main plane is on
    localparam int unsigned PST_AON   = 6;         // Aux plane is on

    // ****************************************
    // Device state codes
    // ****************************************
    localparam logic [1:0] DST_D0 = 2'h0;          // Full power
    localparam logic [1:0] DST_D1 = 2'h1;          // Low power, context kept
    localparam logic [1:0] DST_D3 = 2'h3;          // Off, context lost

    // System sleep sequence
    typedef enum logic [1:0] {SYS_RUN, SYS_SLEEP, SYS_RESUME} dpw_sys_t;

endpackage

/* File: common/dpw_plane_if.sv */
// Purpose: Request, enable and isolation of one power plane
// Assumes: Single clock domain
// Notes:   Core drives the request, sequencer the rest
`timescale 1ns/1ps
`default_nettype none
interface dpw_plane_if;
    logic req;                                     // Plane wanted on
    logic en;                                      // Plane enable out
    logic iso;                                     // Isolation of parts on it
    modport seq  (input req, output en, output iso);
    modport core (output req, input en, input iso);
endinterface
`default_nettype wire

/* File: hw/dpw_core.sv */
// Purpose: Power status events, system wake and modem power planes
// Assumes: One 50 MHz clock, synchronous active-low reset
// Notes:   Registers over a plain port, read data one cycle later
//
// Overview of operation
// - Power status change sets status, raises SCI
// - Wake path runs in hardware only
// - Bridges forward device wake to core
// - Wake only from wake-enabled sources
// - Enabled wake sets status and resumes in the same cycle
// - Wake source record survives status clear
// - D0: controller, phone, speaker all on
// - D1: low power, context kept, on hook
// - D3: controller off, on hook; D2 never produced
// - Ring wakes machine when wake enabled
// - D0 needs both planes, D1 main only
// - Modem wake needs no power plane
// - Aux-off command drops aux enable line
// - Low-power request puts controller low power
// - Off request shuts controller functions down
// - Isolation sequenced with each power plane
// - Modem power state readable by software
// - Ring detect line is a wake source
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dpw_core #(
    parameter int unsigned NDEV = 4                 // Bridged wake sources
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [dpw_pkg::AW-1:0] reg_addr,
    input  wire logic [dpw_pkg::DW-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [dpw_pkg::DW-1:0] reg_rdata,
    input  wire logic                   pwr_status_event,
    input  wire logic [NDEV-1:0]        dev_wake,
    input  wire logic                   ring_detect_line,
    output logic                        sci,
    output logic                        sys_sleep,
    output logic                        sys_resume,
    output logic                        main_plane_en,
    output logic                        aux_plane_enable_line,
    output logic                        main_iso,
    output logic                        aux_iso,
    output logic                        modem_low_power_request,
    output logic                        modem_off_request,
    output logic                        modem_ctrl_on,
    output logic                        modem_ctx_keep,
    output logic                        phone_if_on,
    output logic                        speaker_en,
    output logic                        force_on_hook
);

    // ****************************************
    // Types and constants
    // ****************************************
    localparam int unsigned NEVT = NDEV + 2;        // Events in the vector
    localparam int unsigned DW   = dpw_pkg::DW;

    // Whole state of the block
    typedef struct packed {
        logic [NEVT-1:0]         sts;               // Sticky event status
        logic [NEVT-1:0]         en;                // SCI enables
        logic [NEVT-1:0]         wen;               // Wake enables
        logic [NEVT-1:0]         src;               // Last wake source
        logic                    src_vld;           // Record holds a source
        logic [dpw_pkg::CTL_W-1:0] ctl;             // Plane and modem control
        dpw_pkg::dpw_sys_t       sys;               // Sleep sequence
        logic                    sci;               // Interrupt toward the OS
        logic [DW-1:0]           rdata;             // Read data
    } dpw_state_t;

    localparam dpw_state_t ST_RST = '{
        sts: '0, en: '0, wen: '0, src: '0, src_vld: 1'b0,
        ctl: dpw_pkg::CTL_RST, sys: dpw_pkg::SYS_RUN,
        sci: 1'b0, rdata: '0
    };

    // ****************************************
    // Signals
    // ****************************************
    dpw_state_t      s;                             // Current state
    dpw_state_t      next_s;                        // Next state
    logic [NEVT-1:0] ev_raw;                        // Raw event inputs
    logic [NEVT-1:0] ev_set;                        // Events that latch
    logic [NEVT-1:0] wake_v;                        // Events that may wake
    logic [1:0]      dstate;                        // Modem device state
    logic            need_main;                     // Main plane needed
    logic            need_aux;                      // Aux plane needed
    logic [DW-1:0]   pst;                           // Power state word
    logic            wr_sts;                        // Write to status
    logic            wr_ctl;                        // Write to control

    dpw_plane_if u_main_if ();                      // Main plane link
    dpw_plane_if u_aux_if ();                       // Aux plane link

    // ****************************************
    // Events and wake sources
    // ****************************************

    // Bridged device wake lines enter above the ring line
    assign ev_raw = {dev_wake, ring_detect_line, pwr_status_event};

    // Power status always latches; wake sources only when enabled
    assign ev_set = ev_raw & {s.wen[NEVT-1:1], 1'b1};

    // Ring and device wakes, independent of any plane
    assign wake_v = {ev_set[NEVT-1:1], 1'b0};

    assign wr_sts = reg_wr && (reg_addr == dpw_pkg::OFS_STS);
    assign wr_ctl = reg_wr && (reg_addr == dpw_pkg::OFS_CTL);

    // ****************************************
    // Modem state decode
    // ****************************************

    // Off request wins over low power; D2 is never produced
    always_comb begin
        if (s.ctl[dpw_pkg::CTL_OFF]) begin
            dstate = dpw_pkg::DST_D3;
        end else if (s.ctl[dpw_pkg::CTL_LP]) begin
            dstate = dpw_pkg::DST_D1;
        end else begin
            dstate = dpw_pkg::DST_D0;
        end
    end

    // Plane needs per state
    assign need_main = (dstate != dpw_pkg::DST_D3);
    assign need_aux  = (dstate == dpw_pkg::DST_D0);

    // Readback word of power state
    always_comb begin
        pst                      = '0;
        pst[dpw_pkg::PST_DST+:2] = dstate;
        pst[dpw_pkg::PST_NMAIN]  = need_main;
        pst[dpw_pkg::PST_NAUX]   = need_aux;
        pst[dpw_pkg::PST_SLP]    = (s.sys != dpw_pkg::SYS_RUN);
        pst[dpw_pkg::PST_MON]    = u_main_if.en;
        pst[dpw_pkg::PST_AON]    = u_aux_if.en;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_s = s;

        // Status: software clears by writing ones, a new event wins
        if (wr_sts) begin
            next_s.sts = s.sts & ~reg_wdata[NEVT-1:0];
        end
        next_s.sts = next_s.sts | ev_set;

        // Enables and control
        if (reg_wr && (reg_addr == dpw_pkg::OFS_EN)) begin
            next_s.en = reg_wdata[NEVT-1:0];
        end
        if (reg_wr && (reg_addr == dpw_pkg::OFS_WEN)) begin
            next_s.wen = reg_wdata[NEVT-1:0];
        end
        if (wr_ctl) begin
            next_s.ctl = reg_wdata[dpw_pkg::CTL_W-1:0];
        end

        // A write to the record clears it, unless a wake is recorded in the same cycle
        if (reg_wr && (reg_addr == dpw_pkg::OFS_SRC)) begin
            next_s.src     = '0;
            next_s.src_vld = 1'b0;
        end

        // Sleep sequence: software enters it, wake and resume need no processor
        unique case (s.sys)
            dpw_pkg::SYS_RUN: begin
                // Software requests sleep
                if (wr_ctl && reg_wdata[dpw_pkg::CTL_SLEEP]) begin
                    next_s.sys = dpw_pkg::SYS_SLEEP;
                end
            end
            dpw_pkg::SYS_SLEEP: begin
                // Enabled wake: record source and resume
                if (|wake_v) begin
                    next_s.sys     = dpw_pkg::SYS_RESUME;
                    next_s.src     = wake_v;
                    next_s.src_vld = 1'b1;
                end
            end
            dpw_pkg::SYS_RESUME: begin
                // One cycle resume pulse
                next_s.sys = dpw_pkg::SYS_RUN;
            end
        endcase

        // Interrupt follows enabled status
        next_s.sci = |(next_s.sts & next_s.en);

        // Read data only in the cycle after the strobe
        next_s.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                dpw_pkg::OFS_STS: next_s.rdata = DW'(s.sts);
                dpw_pkg::OFS_EN:  next_s.rdata = DW'(s.en);
                dpw_pkg::OFS_WEN: next_s.rdata = DW'(s.wen);
                dpw_pkg::OFS_SRC: begin
                    next_s.rdata = DW'(s.src);
                    next_s.rdata[dpw_pkg::SRC_VLD] = s.src_vld;
                end
                dpw_pkg::OFS_CTL: next_s.rdata = DW'(s.ctl);
                dpw_pkg::OFS_PST: next_s.rdata = pst;
                default:          next_s.rdata = '0; // Unmapped reads zero
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= ST_RST;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // Plane sequencers
    // ****************************************
    assign u_main_if.req = s.ctl[dpw_pkg::CTL_MAIN];
    assign u_aux_if.req  = s.ctl[dpw_pkg::CTL_AUX];

    // Main plane with its isolation
    dpw_plane_seq #(
        .RST_ON (dpw_pkg::CTL_RST[dpw_pkg::CTL_MAIN])
    ) u_main_seq (
        .clk   (clk),
        .rst_n (rst_n),
        .pl    (u_main_if.seq)
    );

    // Aux plane with its isolation
    dpw_plane_seq #(
        .RST_ON (dpw_pkg::CTL_RST[dpw_pkg::CTL_AUX])
    ) u_aux_seq (
        .clk   (clk),
        .rst_n (rst_n),
        .pl    (u_aux_if.seq)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata               = s.rdata;
    assign sci                     = s.sci;
    assign sys_sleep               = (s.sys == dpw_pkg::SYS_SLEEP);
    assign sys_resume              = (s.sys == dpw_pkg::SYS_RESUME);
    assign main_plane_en           = u_main_if.en;
    assign aux_plane_enable_line   = u_aux_if.en;
    assign main_iso                = u_main_if.iso;
    assign aux_iso                 = u_aux_if.iso;
    assign modem_low_power_request = (dstate == dpw_pkg::DST_D1);
    assign modem_off_request       = (dstate == dpw_pkg::DST_D3);

    // Modem functions per state
    assign modem_ctrl_on  = (dstate != dpw_pkg::DST_D3);
    assign modem_ctx_keep = (dstate != dpw_pkg::DST_D3);
    assign phone_if_on    = (dstate == dpw_pkg::DST_D0);
    assign speaker_en     = (dstate == dpw_pkg::DST_D0);
    assign force_on_hook  = (dstate != dpw_pkg::DST_D0);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_evt_sci: assert property (pwr_status_event && s.en[dpw_pkg::EV_PWR] |=> sci)
        else $error("power event did not raise SCI");

    a_wake_ignored: assert property (
        sys_sleep && !(|(ev_raw[NEVT-1:1] & s.wen[NEVT-1:1])) |=> !sys_resume)
        else $error("resume from a disabled source");

    a_ring_resume: assert property (
        sys_sleep && ring_detect_line && s.wen[dpw_pkg::EV_RING]
        |=> sys_resume && s.sts[dpw_pkg::EV_RING] ##1 !sys_sleep && !sys_resume)
        else $error("ring did not resume the system");

    a_dev_status: assert property (
        sys_sleep && dev_wake[0] && s.wen[dpw_pkg::EV_DEV]
        |=> s.sts[dpw_pkg::EV_DEV] && s.src[dpw_pkg::EV_DEV] && s.src_vld)
        else $error("device wake not recorded");

    a_src_kept: assert property (
        s.src_vld && wr_sts && !sys_sleep |=> s.src_vld && $stable(s.src))
        else $error("wake record lost on status clear");

    a_aux_drop: assert property (
        wr_ctl && !reg_wdata[dpw_pkg::CTL_AUX] ##1 !s.ctl[dpw_pkg::CTL_AUX] [*2]
        |-> ##[0:1] !aux_plane_enable_line)
        else $error("aux enable line stayed up");

    a_d1_state: assert property (
        modem_low_power_request |-> !speaker_en && force_on_hook && modem_ctx_keep && modem_ctrl_on)
        else $error("low power state wrong");

    a_d3_state: assert property (
        modem_off_request |-> !modem_ctrl_on && !modem_low_power_request && force_on_hook)
        else $error("off state wrong");

    a_plane_need: assert property (
        need_aux |-> need_main && phone_if_on && speaker_en)
        else $error("plane need inconsistent");

    a_state_read: assert property (
        reg_rd && reg_addr == dpw_pkg::OFS_PST
        |=> reg_rdata[dpw_pkg::PST_DST+:2] == $past(dstate))
        else $error("state readback wrong");

    a_clear_wins: assert property (
        wr_sts && reg_wdata[dpw_pkg::EV_PWR] && !pwr_status_event |=> !s.sts[dpw_pkg::EV_PWR])
        else $error("status bit not cleared");

    // Resume is a single cycle that always lands back in running
    a_resume_once: assert property (
        sys_resume |=> !sys_resume && !sys_sleep)
        else $error("resume pulse held too long");

    // Wake record is written together with the resume
    a_src_on_resume: assert property (
        sys_resume |-> s.src_vld && (s.src == $past(wake_v)))
        else $error("wake source not recorded");

    // Main scenarios: sleep entry, ring and device wake, SCI, aux plane drop
    c_sleep: cover property (wr_ctl && reg_wdata[dpw_pkg::CTL_SLEEP] && !sys_sleep ##1 sys_sleep);
    c_ring_wake: cover property (sys_sleep && ring_detect_line ##1 sys_resume);
    c_dev_wake: cover property (sys_sleep && |dev_wake ##1 sys_resume);
    c_sci_up: cover property ($rose(sci));
    c_aux_off: cover property ($fell(aux_plane_enable_line));

endmodule
`default_nettype wire

/* File: hw/dpw_plane_seq.sv */
// Purpose: Sequence one power plane with its isolation control
// Assumes: Synchronous active-low reset
// Notes:   Isolation rises before the plane drops, falls after it rises
`timescale 1ns/1ps
`default_nettype none
module dpw_plane_seq #(
    parameter logic RST_ON = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    dpw_plane_if.seq  pl
);

    typedef struct packed {
        logic en;                                  // Plane enable
        logic iso;                                 // Isolation active
    } dpw_seq_t;

    localparam dpw_seq_t SEQ_RST = '{en: RST_ON, iso: ~RST_ON};

    dpw_seq_t s;                                   // Current state
    dpw_seq_t next_s;                              // Next state

    // Next state: plane rises at once, falls one cycle after isolation
    always_comb begin
        next_s     = s;
        next_s.en  = pl.req | (s.en & ~s.iso);
        next_s.iso = ~(pl.req & s.en);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= SEQ_RST;
        end else begin
            s <= next_s;
        end
    end

    assign pl.en  = s.en;
    assign pl.iso = s.iso;

    // ****************************************
    // Checks
    // ****************************************
    a_iso_when_off: assert property (@(posedge clk) disable iff (!rst_n) !pl.en |-> pl.iso)
        else $error("plane off without isolation");
    a_iso_before_drop: assert property (@(posedge clk) disable iff (!rst_n) $fell(pl.en) |-> $past(pl.iso))
        else $error("plane dropped before isolation rose");

endmodule
`default_nettype wire
